// *** pscg_consts.svh ***
// Constants for the port strobe and clock generator block
`ifndef PSCG_CONSTS_SVH
`define PSCG_CONSTS_SVH

// Clock rate and times
`define PSCG_CLK_MHZ        40
`define PSCG_STROBE_NS      1500
`define PSCG_GAP_BASE_NS    8250
`define PSCG_GAP_STEP_NS    750
`define PSCG_UNIT_US        1000
`define PSCG_STROBE_CYC     ((`PSCG_STROBE_NS * `PSCG_CLK_MHZ + 999) / 1000)
`define PSCG_GAP_BASE_CYC   ((`PSCG_GAP_BASE_NS * `PSCG_CLK_MHZ + 999) / 1000)
`define PSCG_GAP_STEP_CYC   ((`PSCG_GAP_STEP_NS * `PSCG_CLK_MHZ + 999) / 1000)
`define PSCG_UNIT_CYC       (`PSCG_UNIT_US * `PSCG_CLK_MHZ)

// Register byte offsets
`define PSCG_OFS_CMD        5'h00
`define PSCG_OFS_EXT_LO     5'h04
`define PSCG_OFS_EXT_HI     5'h08
`define PSCG_OFS_CFG        5'h0c
`define PSCG_OFS_STATUS     5'h10
`define PSCG_OFS_PORT0      5'h14
`define PSCG_OFS_PORT1      5'h18

// Field positions
`define PSCG_CFG_ACK_BIT    3
`define PSCG_CMD_MINOR_LSB  0
`define PSCG_CMD_LO_LSB     8
`define PSCG_CMD_HI_LSB     16
`define PSCG_CMD_LEN_LSB    24

// Reset values
`define PSCG_PRESC_RST      8'h0a
`define PSCG_PORT_RST       8'hff
`define PSCG_PER_RST        8'h05

// Minor command codes
`define PSCG_MIN_STB_HI     8'h0f
`define PSCG_MIN_STB_LO     8'h10
`define PSCG_MIN_LATCH      8'h11
`define PSCG_MIN_PRESC      8'h13
`define PSCG_MIN_CLKEN      8'h14
`define PSCG_MIN_PER0       8'h15
`define PSCG_MIN_PER3       8'h18
`define PSCG_MIN_SYNC       8'h19
`define PSCG_MIN_PH0        8'h1a
`define PSCG_MIN_PH3        8'h1d

`endif

// *** pscg_pkg.sv ***
// Types shared by the port strobe and clock generator block
package pscg_pkg;
	typedef enum logic [2:0] {
		PSCG_IDLE    = 3'b000,
		PSCG_PLACE   = 3'b001,
		PSCG_STROBE  = 3'b010,
		PSCG_RELEASE = 3'b011,
		PSCG_GAP     = 3'b100,
		PSCG_LATCH   = 3'b101
	} pscg_state_t;
endpackage : pscg_pkg

// *** pscg_clk_chan.sv ***
// One clock generator channel with period counters and phase delay
`timescale 1ns/100ps
`include "pscg_consts.svh"
module pscg_clk_chan (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       arst_n,
	// Time base and control
	input  wire logic       step,
	input  wire logic       restart,
	input  wire logic       load,
	input  wire logic [7:0] hi_cnt,
	input  wire logic [7:0] lo_cnt,
	input  wire logic       sync_en,
	input  wire logic       start_lvl,
	input  wire logic [7:0] phase,
	// Channel level
	output logic            level_q
);
	import pscg_pkg::*;

	logic [7:0] hi_q;
	logic [7:0] lo_q;
	logic [8:0] cnt_q;
	logic [7:0] wait_q;

	// A count of zero stands for 256 steps
	function automatic logic [8:0] lim_of(input logic [7:0] v);
		lim_of = (v == 8'h00) ? 9'h100 : {1'b0, v}; // [R15]
	endfunction : lim_of

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			hi_q <= `PSCG_PER_RST;
			lo_q <= `PSCG_PER_RST;
		end else if (load) begin
			hi_q <= hi_cnt; // [R13]
			lo_q <= lo_cnt;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			level_q <= 1'b1;
			cnt_q   <= 9'h000;
			wait_q  <= 8'h00;
		end else if (restart) begin
			cnt_q   <= 9'h000;
			level_q <= sync_en ? start_lvl : 1'b1; // [R17] [R16]
			wait_q  <= sync_en ? phase : 8'h00; // [R18]
		end else if (step) begin
			if (wait_q != 8'h00) begin
				wait_q <= wait_q - 8'h01; // [R18]
			end else if (cnt_q + 9'h001 >= lim_of(level_q ? hi_q : lo_q)) begin
				level_q <= ~level_q; // [R14]
				cnt_q   <= 9'h000;
			end else begin
				cnt_q <= cnt_q + 9'h001;
			end
		end
	end

	sync_level_a: assert property (@(posedge mclk) disable iff (!arst_n) // [R17]
		restart && sync_en |=> level_q == $past(start_lvl))
		else $error("synchronised start level wrong");

	phase_hold_a: assert property (@(posedge mclk) disable iff (!arst_n) // [R18]
		wait_q != 8'h00 && !restart |=> $stable(level_q))
		else $error("channel toggled during phase delay");
endmodule : pscg_clk_chan

// *** pscg_top.sv ***
// Command interpreter: strobed port writes, latch writes and four clock channels
`timescale 1ns/100ps
`include "pscg_consts.svh"
// Overview of operation
// R1 - Host packets carry recipient, model, major, minor, data bytes, length, extension.
// R2 - Minor 15 pulses selected strobe high then low; minor 16 low then high.
// R3 - Each extension byte goes onto port 0 in turn, lowest first, one to eight.
// R4 - Strobe is held at its active level for 1.5 us after each byte.
// R5 - With acknowledge enabled, strobe stays active while acknowledge input is low.
// R6 - After strobe release, port 0 is driven to all ones.
// R7 - Gap after each byte is 8.25 us plus 0.75 us times gap count.
// R8 - Place, strobe, release, all-ones and gap repeat for every extension byte.
// R9 - Host presets strobe pin inactive and port 0 before a strobe command.
// R10 - Minor 17 writes eight bytes to latches, lowest byte to address zero.
// R11 - Minor 19 loads prescaler, reset 10, range 1 to 255, larger is slower.
// R12 - Minor 20 disables pins in low nibble, enables high nibble; disable wins.
// R13 - Minors 21 to 24 load high and low periods of channels 0 to 3.
// R14 - Channel pin high for low-byte count, low for high-byte count, 10 ms steps.
// R15 - Periods span 10 ms to 2.56 s; duty steps of about 0.39 percent.
// R16 - Minor 25 restarts all channels; sync start only for flagged pins.
// R17 - Flagged pins start at the level given in the high byte nibble.
// R18 - Synchronised channels wait their phase delay in 10 ms steps before toggling.
// R19 - All phase delays are cleared once a synchronise command is done.
// R20 - Minors 26 to 29 load phase delay of channels 0 to 3.
// R21 - Host reloads phase delays before every synchronise command.
// R22 - Disabled clock pins keep their ordinary port level, not driven by channels.
module pscg_top #(
	parameter int TICK_UNIT_CYC = `PSCG_UNIT_CYC
) (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        arst_n,
	// Avalon-MM slave
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// Port pins
	output logic      [7:0]  port0_q,
	output logic      [7:0]  port1_q,
	input  wire logic        ack_i,
	// External latch write
	output logic      [2:0]  latch_addr_q,
	output logic      [7:0]  latch_data_q,
	output logic             latch_we_q
);
	import pscg_pkg::*;

	localparam int STB_CYC = `PSCG_STROBE_CYC;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
	                                         input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		be_merge = r;
	endfunction : be_merge

	function automatic logic [7:0] ext_byte(input logic [63:0] ext, input logic [2:0] idx);
		ext_byte = ext[{idx, 3'b000} +: 8];
	endfunction : ext_byte

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	pscg_state_t st_q;
	logic [31:0] cmd_q;
	logic [63:0] ext_q;
	logic        ack_en_q;
	logic [7:0]  base1_q;
	logic [7:0]  presc_q;
	logic [3:0]  en_q;
	logic [3:0]  lvl;
	logic [31:0] rd_mux;
	logic [31:0] cmd_w;
	logic        busy;
	logic        wr_ok;
	logic        go;
	logic        stall;
	logic [7:0]  minor;
	logic [7:0]  dlo;
	logic [7:0]  dhi;
	logic [3:0]  dlen;
	logic [7:0]  rel_per;
	logic [7:0]  rel_ph;
	logic        sync_go;

	assign busy    = (st_q != PSCG_IDLE);
	assign stall   = avs_write && (avs_address == `PSCG_OFS_CMD) && busy;
	assign wr_ok   = avs_write && !avs_waitrequest;
	assign cmd_w   = be_merge(32'h0000_0000, avs_writedata, avs_byteenable);
	assign go      = wr_ok && (avs_address == `PSCG_OFS_CMD);
	assign minor   = cmd_w[`PSCG_CMD_MINOR_LSB +: 8];
	assign dlo     = cmd_w[`PSCG_CMD_LO_LSB +: 8];
	assign dhi     = cmd_w[`PSCG_CMD_HI_LSB +: 8];
	assign dlen    = cmd_w[`PSCG_CMD_LEN_LSB +: 4];
	assign rel_per = minor - `PSCG_MIN_PER0;
	assign rel_ph  = minor - `PSCG_MIN_PH0;
	assign sync_go = go && (minor == `PSCG_MIN_SYNC);

	always_comb begin
		unique case (avs_address)
			`PSCG_OFS_CMD:    rd_mux = cmd_q;
			`PSCG_OFS_EXT_LO: rd_mux = ext_q[31:0];
			`PSCG_OFS_EXT_HI: rd_mux = ext_q[63:32];
			`PSCG_OFS_CFG:    rd_mux = {28'h0000000, ack_en_q, 3'b000};
			`PSCG_OFS_STATUS: rd_mux = {presc_q, 8'h00, lvl, en_q, 7'h00, busy};
			`PSCG_OFS_PORT0:  rd_mux = {24'h000000, port0_q};
			`PSCG_OFS_PORT1:  rd_mux = {24'h000000, port1_q};
			default:          rd_mux = 32'h0000_0000;
		endcase
	end

	// One wait cycle per access; a command write waits while a sequence runs
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
		end else if ((avs_read || avs_write) && avs_waitrequest && !stall) begin
			avs_waitrequest <= 1'b0;
			avs_readdata    <= avs_read ? rd_mux : 32'h0000_0000;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cmd_q    <= 32'h0000_0000;
			ext_q    <= 64'h0000_0000_0000_0000;
			ack_en_q <= 1'b0;
		end else if (wr_ok) begin
			unique case (avs_address)
				`PSCG_OFS_CMD:    cmd_q <= cmd_w;
				`PSCG_OFS_EXT_LO: ext_q[31:0] <= be_merge(ext_q[31:0], avs_writedata, avs_byteenable);
				`PSCG_OFS_EXT_HI: ext_q[63:32] <= be_merge(ext_q[63:32], avs_writedata, avs_byteenable);
				`PSCG_OFS_CFG:    if (avs_byteenable[0]) ack_en_q <= avs_writedata[`PSCG_CFG_ACK_BIT]; // [R5]
				default:          ;
			endcase
		end
	end

	// ----------------------------------------
	// Clock generator settings
	// ----------------------------------------
	logic [7:0] phase_q [4];

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			presc_q <= `PSCG_PRESC_RST;
			en_q    <= 4'h0;
		end else if (go && minor == `PSCG_MIN_PRESC && dlo != 8'h00) begin
			presc_q <= dlo; // [R11]
		end else if (go && minor == `PSCG_MIN_CLKEN) begin
			en_q <= (en_q | dhi[3:0]) & ~dlo[3:0]; // [R12]
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < 4; i++) begin
				phase_q[i] <= 8'h00;
			end
		end else if (sync_go) begin
			for (int i = 0; i < 4; i++) begin
				phase_q[i] <= 8'h00; // [R19]
			end
		end else if (go && minor >= `PSCG_MIN_PH0 && minor <= `PSCG_MIN_PH3) begin
			phase_q[rel_ph[1:0]] <= dlo; // [R20]
		end
	end

	// ----------------------------------------
	// Time base
	// ----------------------------------------
	// One unit is 1 ms, so the reset prescaler gives 10 ms steps
	logic [15:0] unit_cnt_q;
	logic [7:0]  pre_cnt_q;
	logic        step_q;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			unit_cnt_q <= 16'h0000;
			pre_cnt_q  <= 8'h00;
			step_q     <= 1'b0;
		end else if (sync_go) begin
			unit_cnt_q <= 16'h0000; // [R16]
			pre_cnt_q  <= 8'h00;
			step_q     <= 1'b0;
		end else begin
			step_q <= 1'b0;
			if (unit_cnt_q == 16'(TICK_UNIT_CYC - 1)) begin
				unit_cnt_q <= 16'h0000;
				if (pre_cnt_q + 8'h01 >= presc_q) begin
					pre_cnt_q <= 8'h00; // [R11] [R14]
					step_q    <= 1'b1;
				end else begin
					pre_cnt_q <= pre_cnt_q + 8'h01;
				end
			end else begin
				unit_cnt_q <= unit_cnt_q + 16'h0001;
			end
		end
	end

	// ----------------------------------------
	// Clock channels
	// ----------------------------------------
	for (genvar g = 0; g < 4; g++) begin : g_chan
		pscg_clk_chan u_chan (
			.mclk      (mclk),
			.arst_n    (arst_n),
			.step      (step_q),
			.restart   (sync_go),
			.load      (go && minor >= `PSCG_MIN_PER0 && minor <= `PSCG_MIN_PER3 && rel_per[1:0] == 2'(g)),
			.hi_cnt    (dlo),
			.lo_cnt    (dhi),
			.sync_en   (dlo[g]),
			.start_lvl (dhi[g]),
			.phase     (phase_q[g]),
			.level_q   (lvl[g])
		);
	end

	// Channels own pins 0..3 only while enabled
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			port1_q <= `PSCG_PORT_RST;
		end else begin
			port1_q <= {base1_q[7:4], (en_q & lvl) | (~en_q & base1_q[3:0])}; // [R22]
		end
	end

	// ----------------------------------------
	// Strobe and latch sequencer
	// ----------------------------------------
	logic [2:0]  idx_q;
	logic [3:0]  len_q;
	logic [15:0] cnt_q;
	logic [7:0]  gap_q;
	logic [7:0]  mask_q;
	logic        pol_q;
	logic        stb_act_q;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st_q         <= PSCG_IDLE;
			idx_q        <= 3'h0;
			len_q        <= 4'h0;
			cnt_q        <= 16'h0000;
			gap_q        <= 8'h00;
			mask_q       <= 8'h00;
			pol_q        <= 1'b0;
			stb_act_q    <= 1'b0;
			port0_q      <= `PSCG_PORT_RST;
			base1_q      <= `PSCG_PORT_RST;
			latch_addr_q <= 3'h0;
			latch_data_q <= 8'h00;
			latch_we_q   <= 1'b0;
		end else begin
			latch_we_q <= 1'b0;
			if (wr_ok && avs_address == `PSCG_OFS_PORT0 && avs_byteenable[0]) begin
				port0_q <= avs_writedata[7:0];
			end
			if (wr_ok && avs_address == `PSCG_OFS_PORT1 && avs_byteenable[0]) begin
				base1_q <= avs_writedata[7:0];
			end
			unique case (st_q)
				PSCG_IDLE: begin
					if (go && (minor == `PSCG_MIN_STB_HI || minor == `PSCG_MIN_STB_LO)
					    && dlen != 4'h0 && dlen <= 4'h8) begin
						idx_q  <= 3'h0;
						len_q  <= dlen; // [R3]
						gap_q  <= dlo;
						mask_q <= dhi; // [R2]
						pol_q  <= (minor == `PSCG_MIN_STB_HI);
						st_q   <= PSCG_PLACE;
					end else if (go && minor == `PSCG_MIN_LATCH) begin
						idx_q <= 3'h0;
						st_q  <= PSCG_LATCH;
					end
				end
				PSCG_PLACE: begin
					port0_q <= ext_byte(ext_q, idx_q); // [R3]
					st_q    <= PSCG_STROBE;
				end
				PSCG_STROBE: begin
					if (!stb_act_q) begin
						stb_act_q <= 1'b1;
						base1_q   <= pol_q ? (base1_q | mask_q) : (base1_q & ~mask_q); // [R2]
						cnt_q     <= 16'(STB_CYC - 1); // [R4]
					end else if (cnt_q != 16'h0000) begin
						cnt_q <= cnt_q - 16'h0001;
					end else if (!(ack_en_q && !ack_i)) begin // [R5]
						stb_act_q <= 1'b0;
						base1_q   <= pol_q ? (base1_q & ~mask_q) : (base1_q | mask_q); // [R2]
						st_q      <= PSCG_RELEASE;
					end
				end
				PSCG_RELEASE: begin
					port0_q <= 8'hff; // [R6]
					cnt_q   <= 16'(`PSCG_GAP_BASE_CYC) + 16'(`PSCG_GAP_STEP_CYC) * {8'h00, gap_q}
					           - 16'h0001; // [R7]
					st_q    <= PSCG_GAP;
				end
				PSCG_GAP: begin
					if (cnt_q != 16'h0000) begin
						cnt_q <= cnt_q - 16'h0001;
					end else if ({1'b0, idx_q} == len_q - 4'h1) begin
						st_q <= PSCG_IDLE;
					end else begin
						idx_q <= idx_q + 3'h1; // [R8]
						st_q  <= PSCG_PLACE;
					end
				end
				PSCG_LATCH: begin
					latch_we_q   <= 1'b1; // [R10]
					latch_addr_q <= idx_q;
					latch_data_q <= ext_byte(ext_q, idx_q);
					idx_q        <= idx_q + 3'h1;
					if (idx_q == 3'h7) begin
						st_q <= PSCG_IDLE;
					end
				end
				default: st_q <= PSCG_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic [15:0] act_len_q;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			act_len_q <= 16'h0000;
		end else begin
			act_len_q <= stb_act_q ? act_len_q + 16'h0001 : 16'h0000;
		end
	end

	strobe_width_a: assert property (@(posedge mclk) disable iff (!arst_n) // [R4]
		$fell(stb_act_q) |-> $past(act_len_q) >= 16'(STB_CYC - 1))
		else $error("strobe shorter than minimum");

	ack_hold_a: assert property (@(posedge mclk) disable iff (!arst_n) // [R5]
		stb_act_q && ack_en_q && !ack_i |=> stb_act_q)
		else $error("strobe released while acknowledge low");

	all_ones_a: assert property (@(posedge mclk) disable iff (!arst_n) // [R6]
		st_q == PSCG_RELEASE |=> port0_q == 8'hff ##1 st_q == PSCG_GAP)
		else $error("port 0 not all ones after release");

	place_byte_a: assert property (@(posedge mclk) disable iff (!arst_n) // [R3]
		st_q == PSCG_PLACE |=> port0_q == ext_byte(ext_q, $past(idx_q)) && st_q == PSCG_STROBE)
		else $error("wrong byte placed on port 0");

	gap_load_a: assert property (@(posedge mclk) disable iff (!arst_n) // [R7]
		st_q == PSCG_RELEASE |=>
		cnt_q == 16'(`PSCG_GAP_BASE_CYC) + 16'(`PSCG_GAP_STEP_CYC) * {8'h00, $past(gap_q)} - 16'h0001)
		else $error("gap length wrong");

	presc_range_a: assert property (@(posedge mclk) disable iff (!arst_n) // [R11]
		go && minor == `PSCG_MIN_PRESC |=> presc_q != 8'h00 && (presc_q == $past(dlo) || $past(dlo) == 8'h00))
		else $error("prescaler load wrong");

	disable_wins_a: assert property (@(posedge mclk) disable iff (!arst_n) // [R12]
		go && minor == `PSCG_MIN_CLKEN |=> (en_q & $past(dlo[3:0])) == 4'h0)
		else $error("clock pin enabled despite disable");

	phase_clear_a: assert property (@(posedge mclk) disable iff (!arst_n) // [R19]
		sync_go |=> phase_q[0] == 8'h00 && phase_q[1] == 8'h00 && phase_q[2] == 8'h00 && phase_q[3] == 8'h00)
		else $error("phase delays not cleared");

	latch_first_a: assert property (@(posedge mclk) disable iff (!arst_n) // [R10]
		st_q == PSCG_IDLE && go && minor == `PSCG_MIN_LATCH |=>
		##1 latch_we_q && latch_addr_q == 3'h0 [*1] ##7 latch_addr_q == 3'h7)
		else $error("latch sequence wrong");

	pin_keep_a: assert property (@(posedge mclk) disable iff (!arst_n) // [R22]
		!en_q[0] |=> port1_q[0] == $past(base1_q[0]))
		else $error("disabled clock pin driven by channel");
endmodule : pscg_top

// *** pscg_periph.sv ***
// Peripheral model that answers each strobe with a busy acknowledge
`timescale 1ns/100ps
module pscg_periph (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        arst_n,
	// Strobe seen and busy length
	input  wire logic        strobe_on,
	input  wire logic [15:0] busy_cyc,
	// Acknowledge back to the device
	output logic             ack_i
);
	logic [15:0] cnt_q;
	logic        seen_q;

	// Busy starts on the strobe edge, so the device sees a real handshake
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q  <= 16'h0000;
			seen_q <= 1'b0;
		end else begin
			seen_q <= strobe_on;
			if (strobe_on && !seen_q) begin
				cnt_q <= busy_cyc;
			end else if (cnt_q != 16'h0000) begin
				cnt_q <= cnt_q - 16'h0001;
			end
		end
	end
	assign ack_i = (cnt_q == 16'h0000);
endmodule : pscg_periph

// *** testbench.sv ***
// Self-checking bench for the port strobe and clock generator
`timescale 1ns/100ps
`include "pscg_consts.svh"
`define CHK(g, e, m) begin comparisons++; if ((g) !== (e)) begin fails++; \
	$display("ERROR %0t %s got %0h exp %0h", $time, m, g, e); end end
module testbench;
	logic        mclk = 1'b0;
	logic        arst_n = 1'b0;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [7:0]  port0_q, port1_q, latch_data_q;
	logic [2:0]  latch_addr_q;
	logic        latch_we_q, ack_i, son, son_p = 1'b0, lv_p = 1'b1;
	logic [7:0]  smask = 8'h00;
	logic        spol = 1'b1;
	logic [15:0] busy = 16'h0;
	logic [31:0] rng = 32'd28;
	int          fails = 0, comparisons = 0, cyc = 0, nbyte = 0, gexp = 0;
	int          wid = 0, gap = 0, wmin = 60, wmax = 60, csel = 0, run = 0, ce = 0;
	logic [7:0]  exp_b[$];
	logic [10:0] exp_l[$];
	logic [63:0] exp_r[$];
	int          exp_c[$];
	logic [63:0] r;
	logic [10:0] l;
	logic [7:0]  b;

	always #12.5 mclk = ~mclk;
	// No mask means no strobe, whatever the polarity left behind
	assign son = (smask != 8'h00) && (((port1_q & smask) != 8'h00) == spol);

	pscg_top #(.TICK_UNIT_CYC(4)) uut (
		.mclk(mclk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .port0_q(port0_q),
		.port1_q(port1_q), .ack_i(ack_i), .latch_addr_q(latch_addr_q),
		.latch_data_q(latch_data_q), .latch_we_q(latch_we_q)
	);
	pscg_periph u_periph (
		.mclk(mclk), .arst_n(arst_n), .strobe_on(son), .busy_cyc(busy), .ack_i(ack_i)
	);

	// ----------------------------------------
	// Stimulus tasks
	// ----------------------------------------
	function logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction : xs

	task bus(input logic [4:0] a, input logic w, input logic [31:0] d);
		@(posedge mclk);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= w;
		avs_read      <= !w;
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0) @(posedge mclk);
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
	endtask : bus

	task rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
		exp_r.push_back({m, e});
		bus(a, 1'b0, 32'h0);
	endtask : rd

	task cmd(input logic [7:0] mn, input logic [7:0] lo, input logic [7:0] hi, input logic [3:0] ln);
		bus(`PSCG_OFS_CMD, 1'b1, {4'h0, ln, hi, lo, mn});
	endtask : cmd

	task ext(output logic [63:0] x);
		x = {xs(), xs()};
		bus(`PSCG_OFS_EXT_LO, 1'b1, x[31:0]);
		bus(`PSCG_OFS_EXT_HI, 1'b1, x[63:32]);
	endtask : ext

	task strobe_seq(input logic [7:0] mn, input logic [3:0] n, input logic [7:0] g);
		logic [63:0] x;
		ext(x);
		nbyte = 0;
		gexp  = 330 + 30 * int'(g);
		for (int i = 0; i < n; i++) exp_b.push_back(x[8*i+:8]);
		cmd(mn, g, smask, n);
		// Next command stalls until the whole sequence is out
		cmd(8'h00, 8'h00, 8'h00, 4'h0);
	endtask : strobe_seq

	task results;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : results

	// ----------------------------------------
	// Result watcher
	// ----------------------------------------
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 40000) begin
			fails++;
			results();
		end
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
			r = exp_r.size() ? exp_r.pop_front() : {32'hffffffff, 32'hx};
			`CHK(avs_readdata & r[63:32], r[31:0], "read")
		end
		if (latch_we_q === 1'b1) begin
			l = exp_l.size() ? exp_l.pop_front() : 11'hx;
			`CHK({latch_addr_q, latch_data_q}, l, "latch")
		end
		if (son && !son_p) begin
			b = exp_b.size() ? exp_b.pop_front() : 8'hx;
			`CHK(port0_q, b, "byte")
			if (nbyte > 0) `CHK(gap >= gexp && gap <= gexp + 8, 1'b1, "gap")
			nbyte++;
			wid = 0;
		end
		if (son) wid++;
		if (!son && son_p) begin
			`CHK(wid >= wmin && wid <= wmax, 1'b1, "width")
			gap = 0;
		end
		gap++;
		if (gap == 3 && nbyte > 0) `CHK(port0_q, 8'hff, "all ones")
		son_p = son;
		if (port1_q[csel] !== lv_p) begin
			if (exp_c.size()) begin
				ce = exp_c.pop_front();
				`CHK(run, ce, "clock run")
			end
			run = 0;
		end
		run++;
		lv_p = port1_q[csel];
	end

	initial begin
		logic [63:0] x;
		logic        lv;
		repeat (6) @(posedge mclk);
		arst_n <= 1'b1;
		rd(`PSCG_OFS_STATUS, 32'hff00ff01, 32'h0a00f000);
		rd(`PSCG_OFS_PORT0, 32'hff, 32'hff);
		rd(5'h1c, 32'hffffffff, 32'h0);
		// Strobe pin preset inactive and port 0 known first
		bus(`PSCG_OFS_PORT1, 1'b1, 32'h00);
		bus(`PSCG_OFS_PORT0, 1'b1, 32'h00);
		smask = 8'h10;
		strobe_seq(`PSCG_MIN_STB_HI, 4'h3, 8'(xs() % 4));
		for (int i = 0; i < 2; i++) cmd(`PSCG_MIN_STB_HI, 8'h00, smask, (i != 0) ? 4'h9 : 4'h0);
		rd(`PSCG_OFS_STATUS, 32'h1, 32'h0);
		bus(`PSCG_OFS_PORT1, 1'b1, 32'h20);
		bus(`PSCG_OFS_CFG, 1'b1, 32'h8);
		smask = 8'h20;
		spol  = 1'b0;
		busy  = 16'd100;
		wmin  = 100;
		wmax  = 106;
		strobe_seq(`PSCG_MIN_STB_LO, 4'h8, 8'h00);
		smask = 8'h00;
		busy  = 16'd0;
		bus(`PSCG_OFS_CFG, 1'b1, 32'h0);
		ext(x);
		for (int i = 0; i < 8; i++) exp_l.push_back({3'(i), x[8*i+:8]});
		cmd(`PSCG_MIN_LATCH, 8'h00, 8'h00, 4'h8);
		cmd(`PSCG_MIN_PRESC, 8'h02, 8'h00, 4'h0);
		cmd(`PSCG_MIN_PRESC, 8'h00, 8'h00, 4'h0);
		rd(`PSCG_OFS_STATUS, 32'hff000000, 32'h02000000);
		for (int k = 0; k < 4; k++) begin
			cmd(8'(`PSCG_MIN_PER0 + k), 8'(k + 1), 8'h02, 4'h0);
			cmd(8'(`PSCG_MIN_PH0 + k), 8'h03, 8'h00, 4'h0);
		end
		cmd(`PSCG_MIN_CLKEN, 8'h00, 8'h0f, 4'h0);
		// Channel 0 left unflagged restarts high; the others take 1, 0, 1
		cmd(`PSCG_MIN_SYNC, 8'h0e, 8'h0a, 4'h0);
		rd(`PSCG_OFS_STATUS, 32'hff00ff01, 32'h0200bf00);
		for (int k = 0; k < 4; k++) begin
			csel = k;
			@(posedge mclk);
			lv = port1_q[k];
			while (port1_q[k] === lv) @(posedge mclk);
			repeat (2) @(posedge mclk);
			exp_c.push_back(port1_q[k] ? 8 * (k + 1) : 16);
			exp_c.push_back(port1_q[k] ? 16 : 8 * (k + 1));
			while (exp_c.size()) @(posedge mclk);
		end
		cmd(`PSCG_MIN_CLKEN, 8'h0f, 8'h0f, 4'h0);
		bus(`PSCG_OFS_PORT1, 1'b1, 32'h5a);
		rd(`PSCG_OFS_PORT1, 32'hff, 32'h5a);
		rd(`PSCG_OFS_STATUS, 32'h00000f00, 32'h0);
		repeat (4) @(posedge mclk);
		`CHK(exp_b.size() + exp_l.size() + exp_r.size(), 0, "left over")
		results();
	end
endmodule : testbench
